// File: shared/acs_pkg.sv
// shared constants and types of the conversion sequencer
package acs_pkg;
    localparam int ACS_CLK_PERIOD_NS = 50;
    localparam int ACS_GAP_UNIT_NS = 1024000;
    localparam int ACS_GAP_CYC = ACS_GAP_UNIT_NS / ACS_CLK_PERIOD_NS;
    localparam int ACS_SETTLE_SHIFT = 2;
    localparam int ACS_SMPL_SHIFT = 3;
    localparam logic [15:0] ACS_RESULT_RST = 16'h0000;
    localparam logic [9:0] ACS_RAW_RST = 10'h000;

    typedef struct packed {
        logic [2:0] chan;
        logic se;
        logic [1:0] scaling;
        logic [2:0] avg_exp;
        logic chop;
        logic auto_repeat;
        logic [7:0] repeat_gap;
        logic [7:0] store_delay;
        logic [7:0] smpl_time;
        logic [7:0] settle;
    } acs_cfg_type;

    typedef struct packed {
        logic reg_en;
        logic conv_en;
        logic start;
        logic sign;
        logic se;
        logic [1:0] scaling;
        logic [2:0] chan;
    } acs_ana_type;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_SMPL = 5'h02,
        ST_CONV = 5'h04,
        ST_ALIGN = 5'h08,
        ST_GAP = 5'h10
    } acs_state_type;
endpackage

// File: rtl/acs_sequencer.sv
// conversion sequencer for a 10-bit converter core
// Overview of operation
// [RULE1] regulator first, converter after start-up delay
// [RULE2] start-up delay counts four clock cycles each
// [RULE3] software powers converter down when unused
// [RULE4] go starts conversion, reads one while busy
// [RULE5] completion clears go, sets done, stores result
// [RULE6] go request while busy is ignored
// [RULE7] software checks go low before new request
// [RULE8] repeat mode relaunches after each completion
// [RULE9] repeat mode updates result every time
// [RULE10] stop repeat: clear mode, poll go low
// [RULE11] configuration changes only when fully idle
// [RULE12] repeat gap is field times 1.024 ms
// [RULE13] nonzero gap first aligns to slow tick
// [RULE14] sequencing runs on the system clock
// [RULE15] channel codes select inputs and rails
// [RULE16] one selects single-ended, zero differential
// [RULE17] scaling field selects one to four times
// [RULE18] nonzero store delay stores after fixed count
// [RULE19] averaging sums two-power samples, left aligned
// [RULE20] chopping flips offset sign every conversion
// [RULE21] mode cleared: finish current, then stop
`timescale 1ns/1ps
module acs_sequencer
    import acs_pkg::*;
#(
    parameter int GAP_CYC = ACS_GAP_CYC
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic converter_power_on,
    input wire logic go_write,
    input wire logic done_clear,
    input wire acs_cfg_type cfg,
    input wire logic core_done_tgl,
    input wire logic [9:0] core_data,
    output logic conversion_go,
    output logic conversion_done_flag,
    output logic [15:0] sample_result,
    output acs_ana_type ana
);
    // scales a sum of 2**k raw samples to a 16-bit left-aligned word
    function automatic logic [15:0] align16(
        input logic [16:0] sum,
        input logic [2:0] k
    );
        logic [23:0] w;
        w = {sum, 7'h00} << (3'h7 - k);
        return w[23:8];
    endfunction

    // [RULE14] everything below runs on ref_clk alone
    logic tg_s1_q;
    logic tg_s2_q;
    logic tg_s3_q;
    logic [9:0] dat_s1_q;
    logic [9:0] dat_s2_q;
    logic evt_w;

    // core data is stable once the toggle is seen, so a bus sync is safe
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tg_s1_q <= 1'b0;
            tg_s2_q <= 1'b0;
            tg_s3_q <= 1'b0;
            dat_s1_q <= ACS_RAW_RST;
            dat_s2_q <= ACS_RAW_RST;
        end else if (clk_en) begin
            tg_s1_q <= core_done_tgl;
            tg_s2_q <= tg_s1_q;
            tg_s3_q <= tg_s2_q;
            dat_s1_q <= core_data;
            dat_s2_q <= dat_s1_q;
        end
    end

    assign evt_w = tg_s2_q ^ tg_s3_q;

    // power-up group
    logic [9:0] pwr_cnt_q;
    logic [9:0] pwr_cnt_d;
    logic reg_en_q;
    logic reg_en_d;
    logic conv_en_q;
    logic conv_en_d;

    always_comb begin
        pwr_cnt_d = pwr_cnt_q;
        reg_en_d = 1'b1;
        conv_en_d = conv_en_q;
        if (!converter_power_on) begin
            reg_en_d = 1'b0;
            conv_en_d = 1'b0;
            pwr_cnt_d = 10'h000;
        end else if (!conv_en_q && reg_en_q) begin
            if (pwr_cnt_q >= {cfg.settle, 2'h0}) begin // [RULE2]
                conv_en_d = 1'b1; // [RULE1]
            end else begin
                pwr_cnt_d = pwr_cnt_q + 10'h001;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pwr_cnt_q <= 10'h000;
            reg_en_q <= 1'b0;
            conv_en_q <= 1'b0;
        end else if (clk_en) begin
            pwr_cnt_q <= pwr_cnt_d;
            reg_en_q <= reg_en_d;
            conv_en_q <= conv_en_d;
        end
    end

    // free-running slow tick; the gap aligns to it, hence up to 1.024 ms extra
    logic [15:0] tick_cnt_q;
    logic [15:0] tick_cnt_d;
    logic tick_w;

    always_comb begin
        tick_w = (tick_cnt_q == 16'(GAP_CYC - 1));
        tick_cnt_d = tick_w ? 16'h0000 : tick_cnt_q + 16'h0001;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_q <= 16'h0000;
        end else if (clk_en) begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    // sequencing group
    acs_state_type st_q;
    acs_state_type st_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [7:0] n_q;
    logic [7:0] n_d;
    logic [7:0] gap_q;
    logic [7:0] gap_d;
    logic [16:0] acc_q;
    logic [16:0] acc_d;
    logic [9:0] last_q;
    logic [9:0] last_d;
    logic got_q;
    logic got_d;
    logic go_q;
    logic go_d;
    logic done_q;
    logic done_d;
    logic [15:0] res_q;
    logic [15:0] res_d;
    acs_ana_type ana_q;
    acs_ana_type ana_d;
    logic take_w;
    logic fin_w;
    logic [9:0] v_w;
    logic [16:0] sum_w;
    logic [2:0] k_w;
    logic [15:0] smpl_w;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        n_d = n_q;
        gap_d = gap_q;
        acc_d = acc_q;
        last_d = last_q;
        got_d = got_q;
        go_d = go_q;
        res_d = res_q;
        done_d = done_q & ~done_clear;
        ana_d = ana_q;
        ana_d.start = 1'b0;
        ana_d.reg_en = reg_en_d;
        ana_d.conv_en = conv_en_d;
        ana_d.chan = cfg.chan; // [RULE15]
        ana_d.se = cfg.se; // [RULE16]
        ana_d.scaling = cfg.scaling; // [RULE17]
        take_w = 1'b0;
        fin_w = 1'b0;
        v_w = last_q;
        // chopping alone still needs a pair of conversions
        k_w = (cfg.chop && cfg.avg_exp == 3'h0) ? 3'h1 : cfg.avg_exp; // [RULE20]
        smpl_w = {5'h00, cfg.smpl_time, 3'h0};
        if (smpl_w == 16'h0000) begin
            smpl_w = 16'h0001;
        end
        if (go_write && !go_q && conv_en_q) begin
            go_d = 1'b1; // [RULE4] [RULE6]
        end
        unique case (st_q)
            ST_IDLE: begin
                if (go_q && conv_en_q) begin
                    st_d = ST_SMPL;
                    cnt_d = smpl_w;
                    n_d = 8'h00;
                    acc_d = 17'h00000;
                end
            end
            ST_SMPL: begin
                if (cnt_q <= 16'h0001) begin
                    st_d = ST_CONV;
                    ana_d.start = 1'b1;
                    got_d = 1'b0;
                    cnt_d = {8'h00, cfg.store_delay} + 16'h0001;
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            ST_CONV: begin
                if (evt_w) begin
                    got_d = 1'b1;
                end
                if (cfg.store_delay == 8'h00) begin
                    take_w = evt_w;
                    v_w = dat_s2_q;
                end else if (cnt_q <= 16'h0001) begin
                    take_w = 1'b1; // [RULE18]
                    // late core: the previous sample is kept
                    v_w = (got_q || evt_w) ? dat_s2_q : last_q; // [RULE18]
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            ST_ALIGN: begin
                if (tick_w) begin
                    st_d = ST_GAP; // [RULE13]
                    gap_d = cfg.repeat_gap;
                end
            end
            ST_GAP: begin
                if (tick_w) begin
                    if (gap_q <= 8'h01) begin
                        st_d = ST_SMPL; // [RULE12]
                        cnt_d = smpl_w;
                    end else begin
                        gap_d = gap_q - 8'h01;
                    end
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        sum_w = acc_q + {7'h00, v_w};
        if (take_w) begin
            last_d = v_w;
            acc_d = sum_w; // [RULE19]
            n_d = n_q + 8'h01;
            if (cfg.chop) begin
                ana_d.sign = ~ana_q.sign; // [RULE20]
            end
            st_d = ST_SMPL;
            cnt_d = smpl_w;
            if (n_q + 8'h01 == (8'h01 << k_w)) begin
                fin_w = 1'b1;
                res_d = align16(sum_w, k_w); // [RULE19] [RULE9]
                acc_d = 17'h00000;
                n_d = 8'h00;
                if (!cfg.auto_repeat) begin
                    st_d = ST_IDLE; // [RULE21]
                    go_d = 1'b0; // [RULE5]
                end else if (cfg.repeat_gap != 8'h00) begin
                    st_d = ST_ALIGN; // [RULE13]
                end else begin
                    st_d = ST_SMPL; // [RULE8] [RULE12]
                end
            end
        end
        if ((st_q == ST_ALIGN || st_q == ST_GAP) && !cfg.auto_repeat) begin
            st_d = ST_IDLE; // [RULE21]
            go_d = 1'b0;
        end
        if (fin_w) begin
            done_d = 1'b1; // [RULE5]
        end
        if (!converter_power_on) begin
            st_d = ST_IDLE;
            go_d = 1'b0;
            ana_d.start = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= ST_IDLE;
            cnt_q <= 16'h0000;
            n_q <= 8'h00;
            gap_q <= 8'h00;
            acc_q <= 17'h00000;
            last_q <= ACS_RAW_RST;
            got_q <= 1'b0;
            go_q <= 1'b0;
            done_q <= 1'b0;
            res_q <= ACS_RESULT_RST;
            ana_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            n_q <= n_d;
            gap_q <= gap_d;
            acc_q <= acc_d;
            last_q <= last_d;
            got_q <= got_d;
            go_q <= go_d;
            done_q <= done_d;
            res_q <= res_d;
            ana_q <= ana_d;
        end
    end

    assign conversion_go = go_q;
    assign conversion_done_flag = done_q;
    assign sample_result = res_q;
    assign ana = ana_q;

    default clocking cb @(posedge ref_clk iff clk_en);
    endclocking
    default disable iff (!arst_n);

    a_conv_after_reg: assert property ($rose(ana_q.conv_en) |-> $past(ana_q.reg_en)) else $error("converter enabled before regulator"); // [RULE1]
    a_reg_first: assert property ($rose(ana_q.reg_en) |-> !ana_q.conv_en) else $error("regulator and converter rose together"); // [RULE2]
    a_go_taken: assert property (go_write && !go_q && conv_en_q && converter_power_on |=> conversion_go) else $error("go request not taken"); // [RULE4]
    a_go_busy: assert property (st_q != ST_IDLE |-> conversion_go) else $error("go low while busy"); // [RULE4]
    a_done_end: assert property (fin_w && !cfg.auto_repeat && converter_power_on |=> conversion_done_flag && !conversion_go) else $error("completion not flagged"); // [RULE5]
    a_busy_ignore: assert property (st_q == ST_SMPL && cnt_q > 16'h0001 && go_write && converter_power_on |=> st_q == ST_SMPL && cnt_q == $past(cnt_q) - 16'h0001) else $error("request disturbed a conversion"); // [RULE6]
    a_repeat_now: assert property (fin_w && cfg.auto_repeat && cfg.repeat_gap == 8'h00 && converter_power_on |=> st_q == ST_SMPL) else $error("no immediate restart"); // [RULE8]
    a_result_upd: assert property (fin_w |=> sample_result == $past(res_d)) else $error("result not updated"); // [RULE9]
    a_gap_align: assert property (fin_w && cfg.auto_repeat && cfg.repeat_gap != 8'h00 && converter_power_on |=> st_q == ST_ALIGN) else $error("gap skipped alignment"); // [RULE13]
    a_chop_flip: assert property (take_w && cfg.chop && converter_power_on |=> ana_q.sign != $past(ana_q.sign)) else $error("chop sign not flipped"); // [RULE20]
    a_chan_pass: assert property (##1 ana_q.chan == $past(cfg.chan)) else $error("channel not forwarded"); // [RULE15]
    a_done_sticky: assert property (conversion_done_flag && !done_clear |=> conversion_done_flag) else $error("done flag lost"); // [RULE5]

    c_manual_done: cover property (fin_w && !cfg.auto_repeat);
    c_gap_wait: cover property (st_q == ST_GAP && tick_w);
    c_chop_avg: cover property (fin_w && cfg.chop && cfg.avg_exp != 3'h0);
    c_late_store: cover property (take_w && cfg.store_delay != 8'h00 && !got_q && !evt_w);
endmodule // acs_sequencer

// File: bench/acs_core_model.sv
// behavioural model of the analog converter core behind the sequencer
`timescale 1ns/1ps
module acs_core_model
    import acs_pkg::*;
(
    input wire logic ref_clk,
    input wire acs_ana_type ana,
    input wire logic slow,
    output logic core_done_tgl,
    output logic [9:0] core_data
);
    initial begin
        core_done_tgl = 1'b0;
        core_data = 10'h0A5;
    end
    // data settles a cycle ahead of the toggle and then holds,
    // since the sequencer synchronises both; slow never answers
    always @(posedge ref_clk) begin
        if (ana.start === 1'b1 && ana.conv_en === 1'b1 && !slow) begin
            repeat (2) @(posedge ref_clk);
            #5 core_data = core_data + 10'h0C7;
            @(posedge ref_clk);
            #5 core_done_tgl = ~core_done_tgl;
        end
    end
endmodule // acs_core_model

// File: bench/acs_sequencer_bench.sv
// self-checking bench of the conversion sequencer
`timescale 1ns/1ps
module acs_sequencer_bench;
    import acs_pkg::*;
    localparam int GAP = 16;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic go_write = 1'b0;
    logic done_clear = 1'b0;
    logic pwr = 1'b0;
    logic slow = 1'b0;
    acs_cfg_type cfg = '0;
    logic tgl, tq = 1'b0, go, done, psg = 1'b0;
    logic [9:0] raw, last = '0;
    logic [15:0] res;
    logic [16:0] acc = '0;
    acs_ana_type ana;
    int n_mismatch = 0;
    int n_checks = 0;
    int n_start = 0, n_tgl = 0, cyc = 0, t_st = 0, per = 0, nflip = 0;
    int k, p0;

    acs_sequencer #(.GAP_CYC(GAP)) dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(1'b1),
        .converter_power_on(pwr), .go_write(go_write),
        .done_clear(done_clear), .cfg(cfg), .core_done_tgl(tgl),
        .core_data(raw), .conversion_go(go),
        .conversion_done_flag(done), .sample_result(res), .ana(ana));
    acs_core_model core (.ref_clk(ref_clk), .ana(ana), .slow(slow),
        .core_done_tgl(tgl), .core_data(raw));

    always #25 ref_clk = ~ref_clk;
    // watch start pulses and finished samples on the core side
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        tq <= tgl;
        if (ana.start === 1'b1) begin
            n_start <= n_start + 1;
            per <= cyc - t_st;
            t_st <= cyc;
            nflip <= nflip + int'(ana.sign !== psg);
            psg <= ana.sign;
        end
        if (tgl !== tq) begin
            n_tgl <= n_tgl + 1;
            acc <= acc + 17'(raw);
            last <= raw;
        end
    end
    always @(posedge ref_clk) begin
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [16:0] got, exp, input string m);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic pulse(ref logic s);
        tick(1);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    // software polls the start bit low before touching anything
    task automatic idle();
        int j;
        j = 0;
        while (go !== 1'b0 && j < 600) begin
            tick(1);
            j++;
        end
        chk(17'(j < 600), 17'd1, "go stuck");
    endtask
    task automatic wait_tgl(input int n);
        while (n_tgl < n) tick(1);
    endtask
    task automatic conv(input logic [2:0] av, input logic ch);
        int n0, ne;
        cfg.avg_exp = av;
        cfg.chop = ch;
        pulse(done_clear);
        tick(1);
        chk(17'(done), 17'd0, "done clear");
        acc = '0;
        n0 = n_start;
        psg = ana.sign;
        nflip = 0;
        ne = (ch && av == 0) ? 2 : (1 << av);
        pulse(go_write);
        chk(17'(go), 17'd1, "go busy");
        pulse(go_write);
        chk(17'(go), 17'd1, "go held");
        idle();
        tick(1);
        chk(17'(done), 17'd1, "done flag");
        chk(17'(n_start - n0), 17'(ne), "conv count");
        chk(17'(nflip), 17'(ch ? ne - 1 : 0), "chop sign");
        chk(17'(res), {1'b0, 16'(acc << (6 - $clog2(ne)))}, "avg");
    endtask
    // start repeat mode, let three samples pass, stop it again; per holds the period seen
    task automatic repeat_run();
        cfg.auto_repeat = 1'b1;
        pulse(go_write);
        wait_tgl(n_tgl + 3);
        tick(6);
        chk(17'(go), 17'd1, "repeat busy");
        chk(17'(res), {1'b0, last, 6'h00}, "latest");
        cfg.auto_repeat = 1'b0;
        idle();
        k = n_start;
        tick(40);
        chk(17'(n_start), 17'(k), "stopped");
        chk(17'(res), {1'b0, last, 6'h00}, "last kept");
    endtask

    initial begin
        cfg.settle = 8'h02;
        cfg.smpl_time = 8'h01;
        tick(3);
        arst_n = 1'b1;
        chk(17'(res), 17'(ACS_RESULT_RST), "reset result");
        tick(1);
        pwr = 1'b1;
        tick(2);
        chk(17'({ana.reg_en, ana.conv_en}), 17'd2, "regulator first");
        pulse(go_write);
        tick(1);
        chk(17'(go), 17'd0, "go before enable");
        k = 5;
        while (ana.conv_en !== 1'b1 && k < 50) begin
            tick(1);
            k++;
        end
        chk(17'(k >= 8 && k <= 14), 17'd1, "settle delay");
        $display("end of test power");
        conv(3'd0, 1'b0);
        conv(3'd1, 1'b0);
        conv(3'd0, 1'b1);
        conv(3'd2, 1'b1);
        $display("end of test manual");
        conv(3'd0, 1'b0);
        cfg.store_delay = 8'h04;
        slow = 1'b1;
        k = n_tgl;
        pulse(go_write);
        idle();
        chk(17'(res), {1'b0, last, 6'h00}, "old sample kept");
        chk(17'(n_tgl), 17'(k), "no answer");
        slow = 1'b0;
        cfg.store_delay = 8'h00;
        $display("end of test store delay");
        repeat_run();
        p0 = per;
        cfg.repeat_gap = 8'h01;
        repeat_run();
        chk(17'(per - p0 >= GAP && per - p0 <= 2 * GAP + 2), 17'd1,
            "gap");
        cfg.repeat_gap = 8'h00;
        $display("end of test repeat");
        for (int i = 0; i < 8; i++) begin
            cfg.chan = 3'(i);
            cfg.scaling = 2'(i);
            cfg.se = i[0];
            tick(2);
            chk(17'({ana.chan, ana.se, ana.scaling}),
                17'({3'(i), i[0], 2'(i)}), "input select");
        end
        $display("end of test input select");
        pwr = 1'b0;
        tick(2);
        chk(17'({ana.reg_en, ana.conv_en}), 17'd0, "power down");
        $display("end of test power down");
        conclude();
    end
endmodule // acs_sequencer_bench
